/* rtl/buck_mode_consts.svh */
`ifndef BUCK_MODE_CONSTS_SVH
`define BUCK_MODE_CONSTS_SVH
// apb register byte offsets
`define OFS_FREQ_BASE   12'h000
`define OFS_CTRL        12'h004
`define OFS_STATUS      12'h008
// reset values
`define FREQ_BASE_RST   16'h00c8
`define CTRL_EN_RST     1'b1
// field positions
`define CTRL_EN_BIT     0
`define ST_HS_LSB       0
`define ST_LS_LSB       2
`define ST_MODE_LSB     4
`define ST_TWO_BIT      7
`define ST_TRANS_BIT    8
// master clock stretch per voltage code step below full scale
`define FREQ_VSTEP_SHIFT 1
`define CODE_MAX        7'h7f
// timing
`define CLK_FREQ_MHZ    200
`define TRANS_TIME_NS   100000
`define SYNC_STAGES     2
`endif

/* rtl/buck_mode_pkg.sv */
package buck_mode_pkg;
    typedef enum logic [2:0] {
        MODE_PWM_CCM = 3'b001,
        MODE_RPM_CCM = 3'b010,
        MODE_RPM_DCM = 3'b100
    } mode_t;

    typedef struct packed {
        logic       strap;
        logic       power_state_hint;
        logic       dslp;
        logic       ilim;
        logic [6:0] code;
        logic       rpm_trig;
        logic       rpm_end;
        logic [1:0] pwm_end;
        logic [1:0] zero_cur;
    } mode_inputs_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        mode_t       mode;
        logic        ripple_pulse_mode;
        logic        two_ph;
        logic [1:0]  hs;
        logic [1:0]  ls;
        logic [1:0]  dcm_off;
        logic [15:0] per_cnt;
        logic        next_ph;
        logic [15:0] tr_cnt;
        logic [6:0]  code_q;
        logic        dslp_q;
        logic        trig_q;
        logic        en;
        logic [15:0] base;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } top_state_t;
endpackage

/* rtl/mode_input_sync.sv */
`timescale 1ns/1ps
module mode_input_sync #(
    parameter int W = 16
) (
    input  wire logic         REF_CLK_IN,
    input  wire logic         SYS_RST_IN,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    // first stage feeds only the second stage
    always_comb begin
        s_next    = s_reg;
        s_next.s1 = d_in;
        s_next.s2 = s_reg.s1;
    end

    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q_out = s_reg.s2;
endmodule // mode_input_sync

/* rtl/buck_phase_mode_selector.sv */
// How it works
// - strap tied high forces single-phase operation regardless of power-state inputs
// - strap low enables dual-phase, switching one/two phases with load inputs
// - each phase pulse tracked independently; overlap and near-full duty allowed
// - strap low: two interleaved PWM phases on transient or heavy load
// - after any code or deeper-sleep change, hold user phases in PWM CCM
// - hint low or deeper sleep high without transient reduces to one phase
// - hint low, sleep low, no transient, no limit: one phase ripple mode CCM
// - deeper sleep, no transient, no limit: ripple mode, low side off at zero
// - single-phase light load with current limit uses PWM CCM instead
// - ripple mode starts phase-one high side when error amp reaches threshold
// - per-phase PWM frequency is master clock divided by phases in use
// - master clock constant per code, slower for lower codes, base set by software
// - dual-phase PWM ramp cycles alternately serve phase one and phase two
// - ripple mode ends phase-one high side when ramp reaches error amp level
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "buck_mode_consts.svh"
module buck_phase_mode_selector #(
    parameter int TRANS_CYCLES = (`TRANS_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000
) (
    input  wire logic                       REF_CLK_IN,
    input  wire logic                       SYS_RST_IN,
    input  wire buck_mode_pkg::mode_inputs_t MODE_INPUTS_IN,
    input  wire buck_mode_pkg::apb_req_t     APB_REQ_IN,
    output logic                            PREADY_OUT,
    output logic                            PSLVERR_OUT,
    output logic [31:0]                     PRDATA_OUT,
    output logic [1:0]                      HIGH_SIDE_DRIVE_OUT,
    output logic [1:0]                      LOW_SIDE_DRIVE_OUT,
    output logic                            TWO_PHASE_ACTIVE_OUT,
    output logic                            RIPPLE_PULSE_MODE_OUT
);
    import buck_mode_pkg::*;

    localparam logic [15:0] TRANS_LOAD = 16'(TRANS_CYCLES);

    top_state_t   s_reg;
    top_state_t   s_next;
    mode_inputs_t in_s;

    mode_input_sync #(
        .W($bits(mode_inputs_t))
    ) u_sync (
        .REF_CLK_IN(REF_CLK_IN),
        .SYS_RST_IN(SYS_RST_IN),
        .d_in      (MODE_INPUTS_IN),
        .q_out     (in_s)
    );

    logic        code_chg;
    logic        transient;
    logic        heavy;
    logic        boundary;
    logic        tick;
    logic        pwm_ph;
    logic        des_two;
    mode_t       des_mode;
    logic [15:0] period;
    logic        acc;
    logic [11:0] ofs;

    always_comb begin
        s_next   = s_reg;
        ofs      = APB_REQ_IN.paddr[11:0];
        acc      = APB_REQ_IN.psel && APB_REQ_IN.penable && !s_reg.pready;
        // apb: one wait state, answer registered
        s_next.pready  = acc;
        s_next.pslverr = 1'b0;
        s_next.prdata  = 32'h0000_0000;
        if (acc) begin
            case (ofs)
                `OFS_FREQ_BASE: begin
                    s_next.prdata = {16'h0000, s_reg.base};
                end
                `OFS_CTRL: begin
                    s_next.prdata = {31'h0, s_reg.en};
                end
                `OFS_STATUS: begin
                    s_next.prdata[`ST_HS_LSB +: 2]   = s_reg.hs;
                    s_next.prdata[`ST_LS_LSB +: 2]   = s_reg.ls;
                    s_next.prdata[`ST_MODE_LSB +: 3] = s_reg.mode;
                    s_next.prdata[`ST_TWO_BIT]       = s_reg.two_ph;
                    s_next.prdata[`ST_TRANS_BIT]     = s_reg.tr_cnt != 16'h0000;
                end
                default: begin
                    s_next.pslverr = 1'b1;
                end
            endcase
        end
        // writes land only at the edge where the master sees pready high
        if (APB_REQ_IN.psel && APB_REQ_IN.penable && s_reg.pready && APB_REQ_IN.pwrite) begin
            if (ofs == `OFS_FREQ_BASE) begin
                s_next.base = APB_REQ_IN.pwdata[15:0];
            end
            if (ofs == `OFS_CTRL) begin
                s_next.en = APB_REQ_IN.pwdata[`CTRL_EN_BIT];
            end
        end

        // transient window restarts on any code or deeper-sleep change
        code_chg = (in_s.code != s_reg.code_q) || (in_s.dslp != s_reg.dslp_q);
        s_next.code_q = in_s.code;
        s_next.dslp_q = in_s.dslp;
        if (code_chg) begin
            s_next.tr_cnt = TRANS_LOAD;
        end else if (s_reg.tr_cnt != 16'h0000) begin
            s_next.tr_cnt = s_reg.tr_cnt - 16'h0001;
        end
        transient = code_chg || (s_reg.tr_cnt != 16'h0000);
        heavy     = in_s.power_state_hint && !in_s.dslp;

        // mode table
        if (transient || heavy) begin
            des_two  = !in_s.strap;
            des_mode = MODE_PWM_CCM;
        end else begin
            des_two = 1'b0;
            if (in_s.ilim) begin
                des_mode = MODE_PWM_CCM;
            end else if (in_s.dslp) begin
                des_mode = MODE_RPM_DCM;
            end else begin
                des_mode = MODE_RPM_CCM;
            end
        end

        // swapping only between pulses keeps every pulse whole
        boundary = s_reg.hs == 2'b00;
        if (boundary) begin
            s_next.mode   = des_mode;
            s_next.two_ph = des_two;
            s_next.ripple_pulse_mode    = des_mode != MODE_PWM_CCM;
        end

        // master clock: period stretches as the code falls
        period = s_reg.base + (16'(`CODE_MAX - s_reg.code_q) << `FREQ_VSTEP_SHIFT);
        tick   = 1'b0;
        if (s_reg.mode == MODE_PWM_CCM && s_reg.en) begin
            if (s_reg.per_cnt == 16'h0000) begin
                tick           = 1'b1;
                s_next.per_cnt = (period == 16'h0000) ? 16'h0000 : period - 16'h0001;
            end else begin
                s_next.per_cnt = s_reg.per_cnt - 16'h0001;
            end
        end else begin
            s_next.per_cnt = 16'h0000;
        end

        // with two phases, alternate ticks serve alternate phases, halving each phase rate; one phase takes every tick
        pwm_ph = s_reg.two_ph ? s_reg.next_ph : 1'b0;
        if (tick) begin
            s_next.next_ph = s_reg.two_ph ? !s_reg.next_ph : 1'b0;
        end

        s_next.trig_q = in_s.rpm_trig;
        for (int i = 0; i < 2; i++) begin
            // each phase ends on its own comparator, so pulses may overlap
            if (s_reg.mode == MODE_PWM_CCM && in_s.pwm_end[i] && s_reg.hs[i]) begin
                s_next.hs[i] = 1'b0;
            end
            if (tick && pwm_ph == 1'(i)) begin
                s_next.hs[i] = 1'b1;
            end
        end
        if (s_reg.mode != MODE_PWM_CCM) begin
            if (in_s.rpm_end && s_reg.hs[0]) begin
                s_next.hs[0] = 1'b0;
            end
            if (in_s.rpm_trig && !s_reg.trig_q && !s_reg.hs[0] && s_reg.en) begin
                s_next.hs[0] = 1'b1;
            end
        end
        if (!s_reg.en) begin
            s_next.hs = 2'b00;
        end

        for (int i = 0; i < 2; i++) begin
            if (s_next.hs[i]) begin
                s_next.dcm_off[i] = 1'b0;
            end else if (s_reg.mode == MODE_RPM_DCM && in_s.zero_cur[i]) begin
                s_next.dcm_off[i] = 1'b1;
            end
            if (s_reg.mode != MODE_RPM_DCM) begin
                s_next.dcm_off[i] = 1'b0;
            end
            // low side mirrors high side on an active phase only
            s_next.ls[i] = s_reg.en && !s_next.hs[i] && !s_next.dcm_off[i]
                           && (i == 0 || s_reg.two_ph || s_reg.hs[1]);
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            s_reg      <= '0;
            s_reg.mode <= MODE_PWM_CCM;
            s_reg.en   <= `CTRL_EN_RST;
            s_reg.base <= `FREQ_BASE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign PREADY_OUT            = s_reg.pready;
    assign PSLVERR_OUT           = s_reg.pslverr;
    assign PRDATA_OUT            = s_reg.prdata;
    assign HIGH_SIDE_DRIVE_OUT   = s_reg.hs;
    assign LOW_SIDE_DRIVE_OUT    = s_reg.ls;
    assign TWO_PHASE_ACTIVE_OUT  = s_reg.two_ph;
    assign RIPPLE_PULSE_MODE_OUT = s_reg.ripple_pulse_mode;

    property p_strap_single;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        in_s.strap && boundary |=> !s_reg.two_ph;
    endproperty
    a_strap_single: assert property (p_strap_single)
        else $error("strap high but two phases selected");

    property p_dual_transient;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        !in_s.strap && transient && boundary |=> s_reg.two_ph && s_reg.mode == MODE_PWM_CCM;
    endproperty
    a_dual_transient: assert property (p_dual_transient)
        else $error("dual PWM not selected during transient");

    property p_heavy_dual;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        !in_s.strap && in_s.power_state_hint && !in_s.dslp && boundary |=> s_reg.two_ph;
    endproperty
    a_heavy_dual: assert property (p_heavy_dual)
        else $error("heavy load did not select two phases");

    property p_pulse_hold;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        s_reg.mode == MODE_PWM_CCM && s_reg.en && s_reg.hs[1] && !in_s.pwm_end[1] |=> s_reg.hs[1];
    endproperty
    a_pulse_hold: assert property (p_pulse_hold)
        else $error("phase two pulse cut short");

    property p_light_single;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        !transient && (!in_s.power_state_hint || in_s.dslp) && boundary |=> !s_reg.two_ph;
    endproperty
    a_light_single: assert property (p_light_single)
        else $error("light load kept two phases");

    property p_rpm_ccm;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        !transient && !in_s.power_state_hint && !in_s.dslp && !in_s.ilim && boundary
        |=> s_reg.mode == MODE_RPM_CCM;
    endproperty
    a_rpm_ccm: assert property (p_rpm_ccm)
        else $error("ripple CCM not selected");

    property p_dcm_off;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        s_reg.mode == MODE_RPM_DCM && in_s.zero_cur[0] && !s_reg.hs[0] && !in_s.rpm_trig
        |=> !s_reg.ls[0];
    endproperty
    a_dcm_off: assert property (p_dcm_off)
        else $error("low side stayed on at zero current");

    property p_ilim_pwm;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        !transient && (!in_s.power_state_hint || in_s.dslp) && in_s.ilim && boundary
        |=> s_reg.mode == MODE_PWM_CCM;
    endproperty
    a_ilim_pwm: assert property (p_ilim_pwm)
        else $error("current limit did not force PWM");

    property p_rpm_start;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        s_reg.mode != MODE_PWM_CCM && s_reg.en && in_s.rpm_trig && !s_reg.trig_q && !s_reg.hs[0]
        |=> s_reg.hs[0] ##1 1'b1;
    endproperty
    a_rpm_start: assert property (p_rpm_start)
        else $error("ripple threshold did not start a pulse");

    property p_rpm_end;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        s_reg.mode != MODE_PWM_CCM && in_s.rpm_end && s_reg.hs[0] |=> !s_reg.hs[0];
    endproperty
    a_rpm_end: assert property (p_rpm_end)
        else $error("ramp did not end ripple pulse");

    property p_alternate;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        tick && s_reg.two_ph |=> s_reg.next_ph != $past(s_reg.next_ph);
    endproperty
    a_alternate: assert property (p_alternate)
        else $error("dual ramp cycles not alternating");

    property p_mode_at_boundary;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        $changed(s_reg.mode) |-> $past(s_reg.hs) == 2'b00;
    endproperty
    a_mode_at_boundary: assert property (p_mode_at_boundary)
        else $error("mode changed during a pulse");

    property p_trans_pwm;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        transient && boundary |=> s_reg.mode == MODE_PWM_CCM;
    endproperty
    a_trans_pwm: assert property (p_trans_pwm)
        else $error("transient did not force PWM");

    property p_heavy_pwm;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        !transient && in_s.power_state_hint && !in_s.dslp && boundary |=> s_reg.mode == MODE_PWM_CCM;
    endproperty
    a_heavy_pwm: assert property (p_heavy_pwm)
        else $error("heavy load did not select PWM");

    property p_tick_period;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        tick && period != 16'h0000 |=> s_reg.per_cnt == $past(period) - 16'h0001;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("master period not reloaded");

    property p_single_tick;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        tick && !s_reg.two_ph |=> s_reg.hs[0];
    endproperty
    a_single_tick: assert property (p_single_tick)
        else $error("single phase tick did not start phase one");

    property p_single_idle;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        !s_reg.two_ph && !s_reg.hs[1] |=> !s_reg.hs[1] && !s_reg.ls[1];
    endproperty
    a_single_idle: assert property (p_single_idle)
        else $error("phase two switched in single phase");

    property p_ccm_only;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        s_reg.mode != MODE_RPM_DCM |=> s_reg.dcm_off == 2'b00;
    endproperty
    a_ccm_only: assert property (p_ccm_only)
        else $error("low side held off outside DCM");

    property p_hs_ls_excl;
        @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (s_reg.hs & s_reg.ls) == 2'b00;
    endproperty
    a_hs_ls_excl: assert property (p_hs_ls_excl)
        else $error("high and low side on together");
endmodule // buck_phase_mode_selector

/* test/power_stage_model.sv */
`timescale 1ns/1ps
module power_stage_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       slow_in,
    input  wire logic [1:0] hs_in,
    input  wire logic [1:0] ls_in,
    output logic            trig_out,
    output logic            end_out,
    output logic [1:0]      pwm_end_out,
    output logic [1:0]      zero_out
);
    logic [1:0][7:0] on_cnt;
    logic [1:0][7:0] zc_cnt;
    logic [7:0]      gap;
    logic [7:0]      lim;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            on_cnt <= '0;
            zc_cnt <= '0;
            gap    <= '0;
        end else begin
            gap <= (gap == 8'h27) ? 8'h00 : gap + 8'h01;
            for (int i = 0; i < 2; i++) begin
                on_cnt[i] <= hs_in[i] ? on_cnt[i] + 8'h01 : 8'h00;
                zc_cnt[i] <= hs_in[i] ? 8'h00 : zc_cnt[i] + {7'h00, ls_in[i] && zc_cnt[i] < 8'h08};
            end
        end
    end
    // slow on time outlasts the interleave offset, so both high sides overlap
    assign lim = slow_in ? 8'h28 : 8'h03;
    assign pwm_end_out = {on_cnt[1] >= lim, on_cnt[0] >= lim};
    assign end_out = on_cnt[0] >= lim;
    // error amp crosses the threshold once per ripple period, only between pulses
    assign trig_out = gap < 8'h03 && !hs_in[0];
    // current stays at zero until the next high-side pulse
    assign zero_out = {zc_cnt[1] >= 8'h08, zc_cnt[0] >= 8'h08};
endmodule // power_stage_model

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import buck_mode_pkg::*;
    localparam int TR = 200;
    localparam int B  = 32;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         s = 1'b0, p = 1'b1, d = 1'b0, l = 1'b0, slow = 1'b0;
    logic [6:0]   code = 7'h00;
    logic         trig, rend, rdy, err, two, ripple_pulse_mode, e, f;
    logic [1:0]   pend, zc, hs, ls;
    logic [31:0]  rdat, r;
    mode_inputs_t mi;
    apb_req_t     req = '0;
    int           miscompares = 0, checked = 0, c, k;
    always #2.5 clk = ~clk;
    assign mi = {s, p, d, l, code, trig, rend, pend, zc};
    buck_phase_mode_selector #(.TRANS_CYCLES(TR)) u_buck_phase_mode_selector (
        .REF_CLK_IN(clk), .SYS_RST_IN(rst), .MODE_INPUTS_IN(mi), .APB_REQ_IN(req),
        .PREADY_OUT(rdy), .PSLVERR_OUT(err), .PRDATA_OUT(rdat), .HIGH_SIDE_DRIVE_OUT(hs),
        .LOW_SIDE_DRIVE_OUT(ls), .TWO_PHASE_ACTIVE_OUT(two), .RIPPLE_PULSE_MODE_OUT(ripple_pulse_mode));
    power_stage_model u_power_stage_model (.clk_in(clk), .rst_in(rst), .slow_in(slow),
        .hs_in(hs), .ls_in(ls), .trig_out(trig), .end_out(rend), .pwm_end_out(pend), .zero_out(zc));
    task automatic end_sim;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            miscompares++;
            $display("BAD t=%0t wait ran out", $time);
            end_sim();
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] dat);
        int n;
        @(posedge clk);
        req.paddr  <= a;
        req.pwrite <= w;
        req.pwdata <= dat;
        req.psel   <= 1'b1;
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        bound(n, 20);
        r = rdat;
        e = err;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic drive(input logic [10:0] v);
        @(posedge clk);
        {s, p, d, l, code} <= v;
    endtask
    function automatic logic [3:0] exp_mode(logic st, logic ps, logic ds, logic il);
        if (ps && !ds) return {!st, MODE_PWM_CCM};
        if (il) return {1'b0, MODE_PWM_CCM};
        return {1'b0, ds ? MODE_RPM_DCM : MODE_RPM_CCM};
    endfunction
    function automatic logic [31:0] pf(logic [6:0] cd);
        return B + ((32'h7f - cd) << 1);
    endfunction
    // want is {transient, two phases, mode}; mode only moves between pulses, so poll
    task automatic settle(input logic [4:0] want);
        int i;
        i = 0;
        do begin
            apb(1'b0, 32'h8, 32'h0);
            i++;
        end while (r[8:4] !== want && i < 150);
        bound(i, 150);
        chk(r[8:4], want);
        chk({two, ripple_pulse_mode}, {want[3], want[1] | want[2]});
    endtask
    task automatic rise(input int b, output int n);
        logic pv;
        n = 0;
        do begin
            pv = hs[b];
            @(posedge clk);
            n++;
        end while (!(pv === 1'b0 && hs[b] === 1'b1) && n < 1000);
        bound(n, 1000);
    endtask
    task automatic lat(input logic up);
        logic pv;
        int   i;
        i = 0;
        do begin
            pv = up ? trig : rend;
            @(posedge clk);
            i++;
        end while (!(pv === 1'b0 && (up ? trig : rend) === 1'b1) && i < 400);
        bound(i, 400);
        #1;
        i = 1;
        while (hs[0] !== up && i < 20) begin
            @(posedge clk);
            #1;
            i++;
        end
        chk(i, 3);
    endtask
    task automatic zc_chk(input logic exp);
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (zc[0] !== 1'b1 && i < 400);
        bound(i, 400);
        repeat (3) @(posedge clk);
        #1;
        if (hs[0] === 1'b0) chk(ls[0], exp);
    endtask
    initial begin
        k = $urandom(32'hebb0);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 32'h0, 32'h0);
        chk(r, 32'h0000_00c8);
        apb(1'b0, 32'h4, 32'h0);
        chk(r, 32'h1);
        apb(1'b0, 32'hc, 32'h0);
        chk({e, r[30:0]}, 32'h8000_0000);
        apb(1'b1, 32'h0, B);
        $display("test registers done");
        drive({4'b0100, 7'h7d});
        settle({2'b11, MODE_PWM_CCM});
        settle({2'b01, MODE_PWM_CCM});
        rise(0, c);
        rise(0, c);
        chk(c, 2 * pf(7'h7d));
        rise(1, c);
        chk(c, pf(7'h7d));
        slow <= 1'b1;
        f = 1'b0;
        repeat (300) @(posedge clk) f = f | (hs === 2'b11);
        chk(f, 1'b1);
        slow <= 1'b0;
        $display("test dual phase done");
        drive({4'b0001, 7'h7d});
        settle({2'b00, MODE_PWM_CCM});
        rise(0, c);
        rise(0, c);
        chk(c, pf(7'h7d));
        drive({4'b0001, 7'h7f});
        settle({2'b11, MODE_PWM_CCM});
        settle({2'b00, MODE_PWM_CCM});
        rise(0, c);
        rise(0, c);
        chk(c, pf(7'h7f));
        $display("test current limit done");
        drive({4'b0000, 7'h7f});
        settle({2'b00, MODE_RPM_CCM});
        lat(1'b1);
        lat(1'b0);
        zc_chk(1'b1);
        drive({4'b0010, 7'h7f});
        settle({2'b11, MODE_PWM_CCM});
        settle({2'b00, MODE_RPM_DCM});
        zc_chk(1'b0);
        drive({4'b1100, 7'h7f});
        settle({2'b10, MODE_PWM_CCM});
        settle({2'b00, MODE_PWM_CCM});
        $display("test light load done");
        apb(1'b1, 32'h4, 32'h0);
        repeat (50) @(posedge clk);
        chk(hs, 2'b00);
        apb(1'b1, 32'h4, 32'h1);
        $display("test enable done");
        repeat (8) begin
            k = $urandom;
            drive({k[3:0], 2'b11, k[8:4]});
            settle({1'b0, exp_mode(k[3], k[2], k[1], k[0])});
        end
        $display("test random done");
        end_sim();
    end
endmodule // testbench
